// File: probe_latch_pkg.sv
// package with register indexes, control and status field positions, reset values
package probe_latch_pkg;
    // object indexes of the registers
    localparam logic [15:0] IDX_PROBE_CONTROL = 16'h60B8;
    localparam logic [15:0] IDX_PROBE_STATUS = 16'h60B9;
    localparam logic [15:0] IDX_PROBE1_RISE_POSITION = 16'h60BA;
    localparam logic [15:0] IDX_PROBE1_FALL_POSITION = 16'h60BB;
    localparam logic [15:0] IDX_PROBE2_RISE_POSITION = 16'h60BC;
    localparam logic [15:0] IDX_PROBE2_FALL_POSITION = 16'h60BD;
    // control field positions within one probe byte (probe two adds 8)
    localparam int CTL_ENABLE = 0;
    localparam int CTL_CONTINUOUS = 1;
    localparam int CTL_SOURCE = 2;
    localparam int CTL_RISE = 4;
    localparam int CTL_FALL = 5;
    // status field positions within one probe byte
    localparam int STS_ENABLED = 0;
    localparam int STS_RISE_DONE = 1;
    localparam int STS_FALL_DONE = 2;
    localparam int STS_COUNT_LO = 6;
    localparam int PROBE_STRIDE = 8;
    // reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
    localparam logic [1:0] COUNT_RESET = 2'h0;
endpackage

// File: probe_event_if.sv
// interface carrying one probe channel's settings and capture results
`timescale 1ns/1ps
`default_nettype none
interface probe_event_if;
    logic [7:0] ctl;
    logic rise_hit;
    logic fall_hit;
    logic [7:0] status;
    modport channel (input ctl, output rise_hit, output fall_hit, output status);
    modport top (output ctl, input rise_hit, input fall_hit, input status);
endinterface
`default_nettype wire

// File: probe_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module probe_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_r <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_r <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: probe_channel.sv
// one probe channel: edge detection, arming, executed flags and counter
`timescale 1ns/1ps
`default_nettype none
module probe_channel
    import probe_latch_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic ext_sync,
    input wire logic index_sync,
    probe_event_if.channel pe
);
    logic trig;
    logic trig_prev_r;
    logic armed_r;
    logic rise_done_r;
    logic fall_done_r;
    logic [1:0] count_r;
    logic rise_edge;
    logic fall_edge;
    logic en;

    assign en = pe.ctl[CTL_ENABLE];
    assign trig = pe.ctl[CTL_SOURCE] ? index_sync : ext_sync; // [RQ3] [RQ8]
    assign rise_edge = trig & ~trig_prev_r;
    assign fall_edge = ~trig & trig_prev_r;
    // capture gated by enable, arming and per-edge enables
    assign pe.rise_hit = en & armed_r & rise_edge & pe.ctl[CTL_RISE]; // [RQ4] [RQ9]
    assign pe.fall_hit = en & armed_r & fall_edge & pe.ctl[CTL_FALL]; // [RQ5] [RQ10]

    // previous trigger level for edge detection; history kept across source changes
    always_ff @(posedge clk) begin
        if (reset) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= trig;
        end
    end

    // arming: single mode disarms after first capture, disable re-arms
    always_ff @(posedge clk) begin
        if (reset) begin
            armed_r <= 1'b1;
        end else if (!en) begin
            armed_r <= 1'b1; // [RQ22]
        end else if ((pe.rise_hit | pe.fall_hit) && !pe.ctl[CTL_CONTINUOUS]) begin
            armed_r <= 1'b0; // [RQ1] [RQ6]
        end
    end

    // executed flags and execution counter, cleared while disabled
    always_ff @(posedge clk) begin
        if (reset) begin
            rise_done_r <= 1'b0;
            fall_done_r <= 1'b0;
            count_r <= COUNT_RESET;
        end else if (!en) begin
            rise_done_r <= 1'b0; // [RQ22]
            fall_done_r <= 1'b0;
            count_r <= COUNT_RESET;
        end else begin
            if (pe.rise_hit) begin
                rise_done_r <= 1'b1; // [RQ12] [RQ15]
            end
            if (pe.fall_hit) begin
                fall_done_r <= 1'b1; // [RQ13] [RQ16]
            end
            // counts executions in continuous mode, wrapping 3 to 0
            if ((pe.rise_hit | pe.fall_hit) && pe.ctl[CTL_CONTINUOUS]) begin
                count_r <= count_r + 2'h1; // [RQ14] [RQ17] [RQ2] [RQ7]
            end
        end
    end

    // status byte; reserved bits are zero
    always_comb begin
        pe.status = 8'h00; // [RQ23]
        pe.status[STS_ENABLED] = en; // [RQ11]
        pe.status[STS_RISE_DONE] = rise_done_r;
        pe.status[STS_FALL_DONE] = fall_done_r;
        pe.status[STS_COUNT_LO +: 2] = count_r;
    end
endmodule
`default_nettype wire

// File: touch_probe_position_latch.sv
// two-channel touch-probe position latch with object-indexed register access
//
// Overview of operation
// [RQ1] control bit 0 arms probe one; single-shot
// [RQ2] control bit 1 set: capture every trigger
// [RQ3] control bit 2 picks IO or index
// [RQ4] control bit 4 enables rising-edge capture
// [RQ5] control bit 5 enables falling-edge capture
// [RQ6] control bit 8 arms probe two; single-shot
// [RQ7] control bit 9 set: continuous probe two
// [RQ8] control bit 10 picks probe two source
// [RQ9] control bit 12 enables probe two rising
// [RQ10] control bit 13 enables probe two falling
// [RQ11] status bits 0 and 8 mirror enables
// [RQ12] status bit 1: probe one rise done
// [RQ13] status bit 2: probe one fall done
// [RQ14] status bits 6-7 count probe one executions
// [RQ15] status bit 9: probe two rise done
// [RQ16] status bit 10: probe two fall done
// [RQ17] status bits 14-15 count probe two executions
// [RQ18] probe one rise stores position, signed 32
// [RQ19] probe one fall stores separate position
// [RQ20] probe two rise stores own position
// [RQ21] probe two fall stores own position
// [RQ22] disabling clears flags; re-enable re-arms
// [RQ23] reserved status zero; reserved control stored
`timescale 1ns/1ps
`default_nettype none
module touch_probe_position_latch
    import probe_latch_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic probe1_ext_in,
    input wire logic probe2_ext_in,
    input wire logic encoder_index_in,
    input wire logic signed [31:0] feedback_position,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    output logic [31:0] obj_rdata,
    output logic obj_ack,
    output logic obj_err
);
    logic [15:0] control_r;
    logic signed [31:0] probe1_rise_position_r;
    logic signed [31:0] probe1_fall_position_r;
    logic signed [31:0] probe2_rise_position_r;
    logic signed [31:0] probe2_fall_position_r;
    logic ext1_sync;
    logic ext2_sync;
    logic index_sync;
    logic [15:0] status_word;
    logic [31:0] rdata_nxt;
    logic err_nxt;

    probe_event_if ch1 ();
    probe_event_if ch2 ();

    // every pin input passes two flip-flops before use
    probe_sync u_sync_ext1 (.clk(clk), .reset(reset), .async_in(probe1_ext_in), .sync_out(ext1_sync));
    probe_sync u_sync_ext2 (.clk(clk), .reset(reset), .async_in(probe2_ext_in), .sync_out(ext2_sync));
    probe_sync u_sync_index (.clk(clk), .reset(reset), .async_in(encoder_index_in), .sync_out(index_sync));

    // each probe takes its own byte of the control word
    assign ch1.ctl = control_r[7:0]; // [RQ1] [RQ3] [RQ4] [RQ5]
    assign ch2.ctl = control_r[PROBE_STRIDE +: 8]; // [RQ6] [RQ8] [RQ9] [RQ10]

    probe_channel u_probe1 (
        .clk(clk),
        .reset(reset),
        .ext_sync(ext1_sync),
        .index_sync(index_sync),
        .pe(ch1.channel)
    );

    probe_channel u_probe2 (
        .clk(clk),
        .reset(reset),
        .ext_sync(ext2_sync),
        .index_sync(index_sync),
        .pe(ch2.channel)
    );

    assign status_word = {ch2.status, ch1.status}; // [RQ11] [RQ23]

    // control word: all 16 bits stored, reserved ones have no effect
    always_ff @(posedge clk) begin
        if (reset) begin
            control_r <= CONTROL_RESET;
        end else if (obj_wr && obj_index == IDX_PROBE_CONTROL) begin
            control_r <= obj_wdata[15:0]; // [RQ23]
        end
    end

    // position latches; the value is the unsynchronised feedback input in the cycle the synchronised edge is seen
    always_ff @(posedge clk) begin
        if (reset) begin
            probe1_rise_position_r <= POSITION_RESET;
        end else if (ch1.rise_hit) begin
            probe1_rise_position_r <= feedback_position; // [RQ18]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            probe1_fall_position_r <= POSITION_RESET;
        end else if (ch1.fall_hit) begin
            probe1_fall_position_r <= feedback_position; // [RQ19]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            probe2_rise_position_r <= POSITION_RESET;
        end else if (ch2.rise_hit) begin
            probe2_rise_position_r <= feedback_position; // [RQ20]
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            probe2_fall_position_r <= POSITION_RESET;
        end else if (ch2.fall_hit) begin
            probe2_fall_position_r <= feedback_position; // [RQ21]
        end
    end

    // read mux; writes to read-only objects and unknown indexes answer with error
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        err_nxt = 1'b0;
        unique case (obj_index)
            IDX_PROBE_CONTROL: begin
                rdata_nxt = {16'h0000, control_r};
            end
            IDX_PROBE_STATUS: begin
                rdata_nxt = {16'h0000, status_word};
                err_nxt = obj_wr;
            end
            IDX_PROBE1_RISE_POSITION: begin
                rdata_nxt = probe1_rise_position_r;
                err_nxt = obj_wr;
            end
            IDX_PROBE1_FALL_POSITION: begin
                rdata_nxt = probe1_fall_position_r;
                err_nxt = obj_wr;
            end
            IDX_PROBE2_RISE_POSITION: begin
                rdata_nxt = probe2_rise_position_r;
                err_nxt = obj_wr;
            end
            IDX_PROBE2_FALL_POSITION: begin
                rdata_nxt = probe2_fall_position_r;
                err_nxt = obj_wr;
            end
            default: begin
                err_nxt = 1'b1;
            end
        endcase
    end

    // answer registered one cycle after the request; data held until next read
    always_ff @(posedge clk) begin
        if (reset) begin
            obj_rdata <= 32'h0000_0000;
            obj_ack <= 1'b0;
            obj_err <= 1'b0;
        end else begin
            obj_ack <= obj_wr | obj_rd;
            obj_err <= (obj_wr | obj_rd) & err_nxt;
            if (obj_rd) begin
                obj_rdata <= rdata_nxt;
            end
        end
    end
endmodule
`default_nettype wire

// File: tpl_chk.sv
// checker on the object access port of the probe latch
`timescale 1ns/1ps
`default_nettype none
module tpl_chk
    import probe_latch_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [31:0] obj_wdata,
    input wire logic [31:0] obj_rdata,
    input wire logic obj_ack,
    input wire logic obj_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic known;
    logic ctl;
    // index decode kept apart so the properties stay short
    assign known = obj_index >= IDX_PROBE_CONTROL && obj_index <= IDX_PROBE2_FALL_POSITION;
    assign ctl = obj_index == IDX_PROBE_CONTROL;
    property p_ack; (obj_wr || obj_rd) |=> obj_ack; endproperty
    a_ack: assert property (p_ack) else $error("request without ack");
    property p_idle; !(obj_wr || obj_rd) |=> !obj_ack; endproperty
    a_idle: assert property (p_idle) else $error("ack without request");
    property p_err; obj_err |-> obj_ack; endproperty
    a_err: assert property (p_err) else $error("err without ack");
    property p_ro; obj_wr && known && !ctl |=> obj_err; endproperty
    a_ro: assert property (p_ro) else $error("read-only write accepted");
    property p_unk; obj_rd && !known |=> obj_err && obj_rdata == 32'h0000_0000; endproperty
    a_unk: assert property (p_unk) else $error("unknown read not refused");
    property p_ok; obj_rd && !obj_wr && known |=> !obj_err; endproperty
    a_ok: assert property (p_ok) else $error("valid read refused");
    property p_hold; !obj_rd |=> $stable(obj_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_sts;
        obj_rd && obj_index == IDX_PROBE_STATUS |=> obj_rdata[31:16] == 16'h0000 && obj_rdata[5:3] == 3'h0
            && obj_rdata[13:11] == 3'h0;
    endproperty
    a_sts: assert property (p_sts) else $error("reserved status bit set");
    property p_keep;
        obj_wr && !obj_rd && ctl ##1 !obj_wr ##1 obj_rd && !obj_wr && ctl
            |=> obj_rdata[15:0] == $past(obj_wdata[15:0], 3);
    endproperty
    a_keep: assert property (p_keep) else $error("control not stored");
    c_sts: cover property (obj_rd && obj_index == IDX_PROBE_STATUS);
    c_ro: cover property (obj_wr && known && !ctl);
    c_unk: cover property (obj_rd && !known);
endmodule
bind touch_probe_position_latch tpl_chk u_chk (.clk(clk), .reset(reset), .obj_wr(obj_wr),
    .obj_rd(obj_rd), .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err));
`default_nettype wire

// File: probe_pins_model.sv
// model of the probe pins and encoder index that feed the latch
`timescale 1ns/1ps
`default_nettype none
module probe_pins_model (
    input wire logic [2:0] want,
    input wire logic slow,
    output logic probe1_ext_in,
    output logic probe2_ext_in,
    output logic encoder_index_in
);
    // pins follow after a wire delay unrelated to the clock; slow crosses an edge
    // one process drives the pins, so they start low and never have two drivers
    initial begin
        {encoder_index_in, probe2_ext_in, probe1_ext_in} = 3'h0;
        forever begin
            @(want);
            {encoder_index_in, probe2_ext_in, probe1_ext_in} <= #(slow ? 13 : 3) want;
        end
    end
endmodule
`default_nettype wire

// File: touch_probe_position_latch_tb_top.sv
// self-checking bench for the two-channel probe position latch
`timescale 1ns/1ps
`default_nettype none
module touch_probe_position_latch_tb_top;
    import probe_latch_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] want = 3'h0;
    logic slow = 1'b0;
    logic p1, p2, ix, ack, err, e;
    logic signed [31:0] fp = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] idx = 16'h0000;
    logic [31:0] wd = 32'h0000_0000;
    logic [31:0] rdata, d;
    logic [31:0] pe [4] = '{default: 32'h0000_0000};
    int errors = 0;
    int checks = 0;
    int seed = 80;
    always #4 clk = ~clk;
    probe_pins_model u_pins (.want(want), .slow(slow), .probe1_ext_in(p1), .probe2_ext_in(p2),
        .encoder_index_in(ix));
    touch_probe_position_latch u_dut (.clk(clk), .reset(reset), .probe1_ext_in(p1), .probe2_ext_in(p2),
        .encoder_index_in(ix), .feedback_position(fp), .obj_wr(wr), .obj_rd(rd), .obj_index(idx),
        .obj_wdata(wd), .obj_rdata(rdata), .obj_ack(ack), .obj_err(err));
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            errors++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    // one request cycle, then answer picked up while the request line is low
    task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] v);
        @(negedge clk);
        {wr, rd, idx, wd} = {w, !w, i, v};
        @(negedge clk);
        {wr, rd} = 2'h0;
        d = rdata;
        e = err;
    endtask
    task automatic rchk(input string n, input logic [15:0] i, input logic [31:0] x);
        acc(1'b0, i, 32'h0000_0000);
        chk(n, d, x);
    endtask
    // new random position held while the pin settles through the synchroniser
    task automatic edge_to(input int n, input logic v);
        @(negedge clk);
        fp = $random(seed);
        want[n] = v;
        repeat (8) @(negedge clk);
    endtask
    function automatic logic [31:0] sts(input int p, input logic [7:0] b);
        return 32'(b) << (8 * p);
    endfunction
    task automatic stop_test();
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        stop_test();
    end
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 2; s++) begin
                int pn;
                logic [15:0] ri;
                pn = s ? 2 : p;
                ri = IDX_PROBE1_RISE_POSITION + 16'(2 * p);
                slow = 1'($random(seed));
                // single shot, both edges; the unselected source must not trigger
                acc(1'b1, IDX_PROBE_CONTROL, 32'(16'h0031 | 16'(s << 2)) << (8 * p));
                edge_to(s ? p : 2, 1'b1);
                edge_to(s ? p : 2, 1'b0);
                edge_to(pn, 1'b1);
                pe[2 * p] = fp;
                edge_to(pn, 1'b0);
                rchk("rise position", ri, pe[2 * p]);
                rchk("fall position", ri + 16'h0001, pe[2 * p + 1]);
                rchk("status single", IDX_PROBE_STATUS, sts(p, 8'h03));
                acc(1'b1, IDX_PROBE_CONTROL, 32'h0000_0000);
                rchk("status off", IDX_PROBE_STATUS, 32'h0000_0000);
                // continuous, falling edges only: five captures wrap the count to one
                acc(1'b1, IDX_PROBE_CONTROL, 32'(16'h0023 | 16'(s << 2)) << (8 * p));
                repeat (5) begin
                    edge_to(pn, 1'b1);
                    edge_to(pn, 1'b0);
                    pe[2 * p + 1] = fp;
                end
                rchk("status count", IDX_PROBE_STATUS, sts(p, 8'h45));
                rchk("rise kept", ri, pe[2 * p]);
                rchk("fall last", ri + 16'h0001, pe[2 * p + 1]);
                acc(1'b1, IDX_PROBE_CONTROL, 32'h0000_0000);
            end
        end
        // rising edges only on both probes: refused falls must not disarm single shot
        edge_to(0, 1'b1);
        edge_to(1, 1'b1);
        acc(1'b1, IDX_PROBE_CONTROL, 32'h0000_1111);
        edge_to(0, 1'b0);
        edge_to(1, 1'b0);
        edge_to(0, 1'b1);
        pe[0] = fp;
        edge_to(1, 1'b1);
        pe[2] = fp;
        rchk("status rise only", IDX_PROBE_STATUS, 32'h0000_0303);
        rchk("p1 fall refused", IDX_PROBE1_FALL_POSITION, pe[1]);
        rchk("p2 fall refused", IDX_PROBE2_FALL_POSITION, pe[3]);
        rchk("p1 rise only", IDX_PROBE1_RISE_POSITION, pe[0]);
        rchk("p2 rise only", IDX_PROBE2_RISE_POSITION, pe[2]);
        edge_to(0, 1'b0);
        edge_to(1, 1'b0);
        acc(1'b1, IDX_PROBE_CONTROL, 32'h0000_0000);
        acc(1'b1, IDX_PROBE_STATUS, 32'h0000_FFFF);
        chk("read-only write err", 32'(e), 32'h0000_0001);
        rchk("unknown read", 16'h60BE, 32'h0000_0000);
        // reserved control bits only: stored, yet nothing arms
        acc(1'b1, IDX_PROBE_CONTROL, 32'h0000_C8C8);
        rchk("control reserved", IDX_PROBE_CONTROL, 32'h0000_C8C8);
        edge_to(0, 1'b1);
        edge_to(0, 1'b0);
        rchk("status reserved", IDX_PROBE_STATUS, 32'h0000_0000);
        stop_test();
    end
endmodule
`default_nettype wire
